// *** sysctl_pkg.sv ***
// Shared constants for the system control interrupt and sleep gating block
package sysctl_pkg;

	// ********************************
	// Sizes
	// ********************************
	localparam int NUM_IRQ = 3;
	localparam int NUM_PERIPH = 24;
	localparam int GPIO_PORTS = 8;
	localparam int LEVEL_W = 4;

	// ********************************
	// Interrupt source bit positions
	// ********************************
	localparam int IRQ_MAIN_OSC_POWERUP_BIT = 0;
	localparam int IRQ_PLL_LOCKED_BIT = 1;
	localparam int IRQ_BROWNOUT_BIT = 2;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] REG_IRQ_RAW = 8'h00;
	localparam logic [7:0] REG_IRQ_MASKED = 8'h04;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] REG_GATING_CTRL = 8'h10;
	localparam logic [7:0] REG_SLEEP_SEL = 8'h14;
	localparam logic [7:0] REG_DEEP_SEL = 8'h18;
	localparam logic [7:0] REG_GPIO_FAST_SEL = 8'h1C;
	localparam logic [7:0] REG_REGULATOR_CTRL = 8'h20;
	localparam logic [7:0] REG_FLASH_SIZE = 8'h24;
	localparam logic [7:0] REG_VIEW_CTRL = 8'h28;
	localparam logic [7:0] REG_IRQ_VIEW = 8'h2C;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int GATING_EN_BIT = 0;
	localparam int VIEW_MASKED_BIT = 0;
	localparam logic [NUM_IRQ-1:0] IRQ_ENABLE_RESET = 3'h0;
	localparam logic [GPIO_PORTS-1:0] GPIO_FAST_RESET = 8'h00;
	localparam logic [GPIO_PORTS-1:0] GPIO_SELECTABLE = 8'hB7;
	localparam logic [NUM_PERIPH-1:0] PERIPH_SEL_RESET = 24'h000000;
	localparam logic GATING_RESET = 1'b0;
	localparam logic VIEW_RESET = 1'b0;

	// Regulator codes step 0.05 V from 2.25 V (code 0) to 2.75 V (code 10)
	localparam logic [LEVEL_W-1:0] REG_LEVEL_LOWEST = 4'h0;
	localparam logic [LEVEL_W-1:0] REG_LEVEL_NOMINAL = 4'h5;
	localparam logic [LEVEL_W-1:0] REG_LEVEL_HIGHEST = 4'hA;

	// ********************************
	// Power modes
	// ********************************
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP = 2'b10
	} power_mode_t;

endpackage

// *** sysctl_link_if.sv ***
// Carrier between the register core, the interrupt bank and the clock gate bank
`timescale 1ns/100ps
interface sysctl_link_if
	import sysctl_pkg::*;
	();
	logic [NUM_IRQ-1:0] evt;
	logic [NUM_IRQ-1:0] clr;
	logic [NUM_IRQ-1:0] raw;
	logic gate_en;
	power_mode_t mode;
	logic [NUM_PERIPH-1:0] run_sel;
	logic [NUM_PERIPH-1:0] sleep_sel;
	logic [NUM_PERIPH-1:0] deep_sel;
	logic [NUM_PERIPH-1:0] wake_req;
	logic [NUM_PERIPH-1:0] clk_en;
	logic wake;

	modport ctl (output evt, clr, gate_en, mode, run_sel, sleep_sel, deep_sel, wake_req,
		input raw, clk_en, wake);
	modport irq (input evt, clr, output raw);
	modport gate (input gate_en, mode, run_sel, sleep_sel, deep_sel, wake_req,
		output clk_en, wake);
endinterface

// *** irq_status_bank.sv ***
// Sticky raw status bits for the system control interrupt sources
`timescale 1ns/100ps
module irq_status_bank
	import sysctl_pkg::*;
	(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	sysctl_link_if.irq link // Events in, clears in, raw status out
);

	logic [NUM_IRQ-1:0] raw_ff;
	logic [NUM_IRQ-1:0] nxt_raw;

	// Set wins over a clear landing in the same cycle
	assign nxt_raw = (raw_ff & ~link.clr) | link.evt;
	assign link.raw = raw_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_ff <= '0;
		end else begin
			raw_ff <= nxt_raw;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_event_sets_bit: assert property ((|link.evt) |=> ((link.raw & $past(link.evt)) == $past(link.evt)))
		else $error("event did not set its status bit");
	chk_clear_exact_bits: assert property ((|link.clr) |=> ((link.raw & $past(link.clr) & ~$past(link.evt)) == '0))
		else $error("cleared source still pending");
	chk_sticky_hold: assert property (1'b1 |=> (($past(link.raw) & ~$past(link.clr) & ~link.raw) == '0))
		else $error("status bit dropped without a clear");

endmodule

// *** periph_clock_gate.sv ***
// Per-peripheral clock enables for run, sleep and deep-sleep
`timescale 1ns/100ps
module periph_clock_gate
	import sysctl_pkg::*;
	(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	sysctl_link_if.gate link // Mode and selections in, enables out
);

	logic [NUM_PERIPH-1:0] clk_en_ff;
	logic [NUM_PERIPH-1:0] nxt_clk_en;
	logic wake_ff;
	logic nxt_wake;
	logic [NUM_PERIPH-1:0] sleep_en;
	logic [NUM_PERIPH-1:0] deep_en;

	// Selections stay stored while gating is off, they just have no effect
	assign sleep_en = link.gate_en ? (link.run_sel & link.sleep_sel) : link.run_sel;
	assign deep_en = link.gate_en ? (link.run_sel & link.deep_sel) : link.run_sel;
	assign nxt_clk_en = (link.mode == MODE_SLEEP) ? sleep_en :
		(link.mode == MODE_DEEP) ? deep_en : link.run_sel;
	// Only clocked peripherals can raise a wake-up
	assign nxt_wake = (link.mode != MODE_RUN) && (|(link.wake_req & nxt_clk_en));

	assign link.clk_en = clk_en_ff;
	assign link.wake = wake_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_en_ff <= '0;
			wake_ff <= 1'b0;
		end else begin
			clk_en_ff <= nxt_clk_en;
			wake_ff <= nxt_wake;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_gating_off_run: assert property (!link.gate_en |=> (link.clk_en == $past(link.run_sel)))
		else $error("gating off but enables differ from run mode");
	chk_deep_select: assert property ((link.gate_en && link.mode == MODE_DEEP)
		|=> (link.clk_en == ($past(link.run_sel) & $past(link.deep_sel))))
		else $error("deep-sleep enables wrong");
	chk_deep_wake: assert property ((link.gate_en && link.mode == MODE_DEEP
		&& (|(link.wake_req & link.run_sel & link.deep_sel))) |=> link.wake)
		else $error("selected peripheral could not wake the core");

endmodule

// *** sysctl_irq_sleep.sv ***
// Register core of the system control interrupt and sleep gating block
//
// Summary of operation
// - In gated deep-sleep, selected peripherals stay clocked and may wake the core.
// - Gating off: sleep modes clock the run-enabled peripherals exactly as in run.
// - One gating bit decides whether stored sleep selections take effect.
// - A read-only register gives the flash size in bytes.
// - A set fast-bus bit routes that GPIO port over the fast bus alias.
// - A cleared fast-bus bit returns the port to the peripheral bus.
// - Three sources: oscillator power-up, PLL lock, brown-out, each own bit.
// - Clear drops the sources written as one, nothing else; a source whose event lands in the same cycle stays set.
// - Only enabled pending sources drive the core interrupt line.
// - Raw and masked status views are both readable.
// - Regulator level is a read/write field, resetting to nominal, plus/minus ten percent.
// - Reading the regulator field returns the level currently held.
// - A source status bit stays set until software clears it.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module sysctl_irq_sleep
	import sysctl_pkg::*;
	#(
	parameter int NUM_P = NUM_PERIPH, // Peripherals with clock enables
	parameter logic [31:0] FLASH_SIZE_BYTES = 32'h0001_0000, // Plain default, set per die
	parameter logic [GPIO_PORTS-1:0] FAST_SELECTABLE = GPIO_SELECTABLE // Ports with a fast alias
	) (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic main_osc_powerup_irq_i, // Oscillator powered up, pulse
	input wire logic pll_locked_irq_i, // PLL locked, pulse
	input wire logic brownout_irq_i, // Brown-out seen, pulse
	input wire logic [1:0] power_mode_i, // Run, sleep or deep-sleep
	input wire logic [NUM_PERIPH-1:0] periph_run_sel_i, // Run-mode enables
	input wire logic [NUM_PERIPH-1:0] periph_wake_req_i, // Wake requests
	output logic [NUM_PERIPH-1:0] periph_clk_en_o, // Peripheral clock enables
	output logic wake_o, // Wake-up to the core
	output logic irq_o, // To core_interrupt_controller
	output logic [GPIO_PORTS-1:0] gpio_fast_sel_o, // Port on fast bus alias
	output logic [LEVEL_W-1:0] regulator_level_code_o // core_voltage_regulator level
);

	// ********************************
	// Bus slave
	// ********************************
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic req_new;
	logic req_done;
	logic wr_done;
	logic [31:0] byte_mask;
	logic [31:0] wr_bits;

	// Request completes at the edge where ack is seen high
	assign req_new = wb_cyc_i && wb_stb_i && !ack_ff;
	assign req_done = wb_cyc_i && wb_stb_i && ack_ff;
	assign wr_done = req_done && wb_we_i;
	assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_bits = wb_dat_i & byte_mask;

	logic wr_enable;
	logic wr_clear;
	logic wr_gating;
	logic wr_sleep;
	logic wr_deep;
	logic wr_fast;
	logic wr_level;
	logic wr_view;

	assign wr_enable = wr_done && (wb_adr_i == REG_IRQ_ENABLE);
	assign wr_clear = wr_done && (wb_adr_i == REG_IRQ_CLEAR);
	assign wr_gating = wr_done && (wb_adr_i == REG_GATING_CTRL);
	assign wr_sleep = wr_done && (wb_adr_i == REG_SLEEP_SEL);
	assign wr_deep = wr_done && (wb_adr_i == REG_DEEP_SEL);
	assign wr_fast = wr_done && (wb_adr_i == REG_GPIO_FAST_SEL);
	assign wr_level = wr_done && (wb_adr_i == REG_REGULATOR_CTRL);
	assign wr_view = wr_done && (wb_adr_i == REG_VIEW_CTRL);

	// ********************************
	// Control registers
	// ********************************
	logic [NUM_IRQ-1:0] irq_en_ff;
	logic gate_en_ff;
	logic view_sel_ff;
	logic [NUM_PERIPH-1:0] sleep_sel_ff;
	logic [NUM_PERIPH-1:0] deep_sel_ff;
	logic [GPIO_PORTS-1:0] fast_sel_ff;
	logic [LEVEL_W-1:0] level_ff;
	logic irq_ff;

	logic [NUM_IRQ-1:0] nxt_irq_en;
	logic nxt_gate_en;
	logic nxt_view_sel;
	logic [NUM_PERIPH-1:0] nxt_sleep_sel;
	logic [NUM_PERIPH-1:0] nxt_deep_sel;
	logic [GPIO_PORTS-1:0] nxt_fast_sel;
	logic [LEVEL_W-1:0] nxt_level;
	logic [LEVEL_W-1:0] merged_level;
	logic level_ok;

	// Byte-lane merge keeps lanes that were not enabled
	assign nxt_irq_en = (irq_en_ff & ~byte_mask[NUM_IRQ-1:0]) | wr_bits[NUM_IRQ-1:0];
	assign nxt_gate_en = byte_mask[GATING_EN_BIT] ? wb_dat_i[GATING_EN_BIT] : gate_en_ff;
	assign nxt_view_sel = byte_mask[VIEW_MASKED_BIT] ? wb_dat_i[VIEW_MASKED_BIT] : view_sel_ff;
	assign nxt_sleep_sel = (sleep_sel_ff & ~byte_mask[NUM_PERIPH-1:0]) | wr_bits[NUM_PERIPH-1:0];
	assign nxt_deep_sel = (deep_sel_ff & ~byte_mask[NUM_PERIPH-1:0]) | wr_bits[NUM_PERIPH-1:0];
	// Ports without a fast alias keep their select bit at zero
	assign nxt_fast_sel = ((fast_sel_ff & ~byte_mask[GPIO_PORTS-1:0]) | wr_bits[GPIO_PORTS-1:0])
		& FAST_SELECTABLE;
	assign merged_level = (level_ff & ~byte_mask[LEVEL_W-1:0]) | wr_bits[LEVEL_W-1:0];
	// Codes past the highest step are dropped so the regulator never sees them
	assign level_ok = (merged_level >= REG_LEVEL_LOWEST) && (merged_level <= REG_LEVEL_HIGHEST);
	assign nxt_level = level_ok ? merged_level : level_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_ff <= IRQ_ENABLE_RESET;
			gate_en_ff <= GATING_RESET;
			fast_sel_ff <= GPIO_FAST_RESET;
			view_sel_ff <= VIEW_RESET;
			sleep_sel_ff <= PERIPH_SEL_RESET;
			deep_sel_ff <= PERIPH_SEL_RESET;
			level_ff <= REG_LEVEL_NOMINAL;
		end else begin
			if (wr_enable) begin
				irq_en_ff <= nxt_irq_en;
			end
			if (wr_gating) begin
				gate_en_ff <= nxt_gate_en;
			end
			if (wr_view) begin
				view_sel_ff <= nxt_view_sel;
			end
			if (wr_sleep) begin
				sleep_sel_ff <= nxt_sleep_sel;
			end
			if (wr_deep) begin
				deep_sel_ff <= nxt_deep_sel;
			end
			if (wr_fast) begin
				fast_sel_ff <= nxt_fast_sel;
			end
			if (wr_level) begin
				level_ff <= nxt_level;
			end
		end
	end

	// ********************************
	// Interrupt sources
	// ********************************
	sysctl_link_if link ();

	assign link.evt[IRQ_MAIN_OSC_POWERUP_BIT] = main_osc_powerup_irq_i;
	assign link.evt[IRQ_PLL_LOCKED_BIT] = pll_locked_irq_i;
	assign link.evt[IRQ_BROWNOUT_BIT] = brownout_irq_i;
	// Clear acts at the completing edge, so a late posted write clears late
	assign link.clr = wr_clear ? wr_bits[NUM_IRQ-1:0] : '0;

	logic [NUM_IRQ-1:0] masked_status;
	logic [NUM_IRQ-1:0] view_status;

	assign masked_status = link.raw & irq_en_ff;
	assign view_status = view_sel_ff ? masked_status : link.raw;

	irq_status_bank u_irq_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.link(link.irq)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |masked_status;
		end
	end

	// ********************************
	// Peripheral clock gating
	// ********************************
	assign link.gate_en = gate_en_ff;
	assign link.mode = power_mode_t'(power_mode_i);
	assign link.run_sel = periph_run_sel_i;
	assign link.sleep_sel = sleep_sel_ff;
	assign link.deep_sel = deep_sel_ff;
	assign link.wake_req = periph_wake_req_i;

	periph_clock_gate u_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.link(link.gate)
	);

	// ********************************
	// Read path
	// ********************************
	logic [31:0] rd_data;

	assign rd_data =
		(wb_adr_i == REG_IRQ_RAW) ? {29'h0, link.raw} :
		(wb_adr_i == REG_IRQ_MASKED) ? {29'h0, masked_status} :
		(wb_adr_i == REG_IRQ_ENABLE) ? {29'h0, irq_en_ff} :
		(wb_adr_i == REG_GATING_CTRL) ? {31'h0, gate_en_ff} :
		(wb_adr_i == REG_SLEEP_SEL) ? {8'h0, sleep_sel_ff} :
		(wb_adr_i == REG_DEEP_SEL) ? {8'h0, deep_sel_ff} :
		(wb_adr_i == REG_GPIO_FAST_SEL) ? {24'h0, fast_sel_ff} :
		(wb_adr_i == REG_REGULATOR_CTRL) ? {28'h0, level_ff} :
		(wb_adr_i == REG_FLASH_SIZE) ? FLASH_SIZE_BYTES :
		(wb_adr_i == REG_VIEW_CTRL) ? {31'h0, view_sel_ff} :
		(wb_adr_i == REG_IRQ_VIEW) ? {29'h0, view_status} : 32'h0;

	assign nxt_dat = req_new ? rd_data : dat_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
		end else begin
			ack_ff <= req_new;
			dat_ff <= nxt_dat;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign irq_o = irq_ff;
	assign periph_clk_en_o = link.clk_en;
	assign wake_o = link.wake;
	assign gpio_fast_sel_o = fast_sel_ff;
	assign regulator_level_code_o = level_ff;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_fast_write;
		wr_fast ##1 1'b1;
	endsequence

	sequence s_none_pending;
		((link.raw & irq_en_ff) == '0) [*2];
	endsequence

	chk_ack_next_cycle: assert property (req_new |=> wb_ack_o)
		else $error("no ack one cycle after request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_irq_gated: assert property (s_none_pending |-> !irq_o)
		else $error("interrupt raised with no enabled source");
	chk_irq_pending: assert property (((link.raw & irq_en_ff) != '0) |=> irq_o)
		else $error("enabled pending source not signalled");
	chk_level_range: assert property (regulator_level_code_o <= REG_LEVEL_HIGHEST)
		else $error("regulator code beyond highest step");
	chk_fast_sel_update: assert property (s_fast_write |-> (gpio_fast_sel_o
		== $past(nxt_fast_sel)))
		else $error("fast bus select not updated by write");
	chk_fast_sel_mask: assert property ((gpio_fast_sel_o & ~FAST_SELECTABLE) == '0)
		else $error("fast bus select on port without alias");
	chk_fast_sel_hold: assert property (!wr_fast |=> $stable(gpio_fast_sel_o))
		else $error("fast bus select changed without a write");

	// ********************************
	// Register checks
	// ********************************
	// Each write sequence ends in the cycle that first shows the new value
	sequence s_enable_write;
		wr_enable ##1 1'b1;
	endsequence

	sequence s_gating_write;
		wr_gating ##1 1'b1;
	endsequence

	sequence s_level_write;
		wr_level ##1 1'b1;
	endsequence

	sequence s_flash_read;
		req_new && (wb_adr_i == REG_FLASH_SIZE);
	endsequence

	sequence s_view_read;
		req_new && (wb_adr_i == REG_IRQ_VIEW);
	endsequence

	chk_reset_controls: assert property ($fell(rst_i) |-> ((irq_en_ff == IRQ_ENABLE_RESET)
		&& (gate_en_ff == GATING_RESET) && (gpio_fast_sel_o == GPIO_FAST_RESET)))
		else $error("controls not at reset values");
	chk_reset_level: assert property ($fell(rst_i) |-> (regulator_level_code_o == REG_LEVEL_NOMINAL))
		else $error("regulator code not nominal after reset");
	chk_enable_update: assert property (s_enable_write |-> (irq_en_ff == $past(nxt_irq_en)))
		else $error("enable register not updated by write");
	chk_enable_hold: assert property (!wr_enable |=> $stable(irq_en_ff))
		else $error("enable register changed without a write");
	chk_gating_update: assert property (s_gating_write |-> (gate_en_ff == $past(nxt_gate_en)))
		else $error("gating bit not updated by write");
	chk_gating_hold: assert property (!wr_gating |=> $stable(gate_en_ff))
		else $error("gating bit changed without a write");
	chk_sleep_update: assert property (wr_sleep |=> (sleep_sel_ff == $past(nxt_sleep_sel)))
		else $error("sleep selection not updated by write");
	chk_sleep_kept: assert property (!wr_sleep |=> $stable(sleep_sel_ff))
		else $error("sleep selection lost");
	chk_deep_update: assert property (wr_deep |=> (deep_sel_ff == $past(nxt_deep_sel)))
		else $error("deep-sleep selection not updated by write");
	chk_deep_kept: assert property (!wr_deep |=> $stable(deep_sel_ff))
		else $error("deep-sleep selection lost");
	chk_level_update: assert property (s_level_write |-> (regulator_level_code_o == $past(nxt_level)))
		else $error("regulator code not updated by write");
	chk_level_refused: assert property ((wr_level && !level_ok) |=> $stable(regulator_level_code_o))
		else $error("out of range regulator code accepted");
	chk_level_hold: assert property (!wr_level |=> $stable(regulator_level_code_o))
		else $error("regulator code changed without a write");
	chk_flash_read: assert property (s_flash_read
		|=> (wb_dat_o == FLASH_SIZE_BYTES))
		else $error("flash size read wrong");
	chk_raw_read: assert property ((req_new && (wb_adr_i == REG_IRQ_RAW))
		|=> (wb_dat_o == {29'h0, $past(link.raw)}))
		else $error("raw status read wrong");
	chk_masked_read: assert property ((req_new && (wb_adr_i == REG_IRQ_MASKED))
		|=> (wb_dat_o == {29'h0, $past(link.raw & irq_en_ff)}))
		else $error("masked status read wrong");
	chk_view_read: assert property (s_view_read
		|=> (wb_dat_o[NUM_IRQ-1:0] == ($past(view_sel_ff) ? $past(masked_status) : $past(link.raw))))
		else $error("selected status view read wrong");
	chk_level_read: assert property ((req_new && (wb_adr_i == REG_REGULATOR_CTRL))
		|=> (wb_dat_o == {28'h0, $past(regulator_level_code_o)}))
		else $error("regulator code read wrong");
	chk_read_hold: assert property (!req_new |=> $stable(wb_dat_o))
		else $error("read data changed without a request");

endmodule

// *** event_source.sv ***
// Model of the oscillator, PLL and supply monitors that raise system events
`timescale 1ns/100ps
module event_source (
	input wire logic clk_i, // System clock
	input wire logic [2:0] fire_i, // Request one event per set bit
	output logic osc_o, // Oscillator powered up
	output logic pll_o, // PLL locked
	output logic bor_o // Brown-out seen
);
	// ****************
	// Event pulses
	// ****************
	// Registered so each event is a clean one-cycle pulse after the request
	always_ff @(posedge clk_i) begin
		osc_o <= fire_i[0];
		pll_o <= fire_i[1];
		bor_o <= fire_i[2];
	end
endmodule

// *** tb_sysctl_irq_sleep.sv ***
// Self-checking bench for the system control interrupt and sleep gating block
`timescale 1ns/100ps
module tb_sysctl_irq_sleep;
	import sysctl_pkg::*;
	localparam logic [31:0] FLASH = 32'h0002_0000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, osc, pll, bor, irq, wake;
	logic [2:0] fire = 3'h0;
	power_mode_t pm = MODE_RUN;
	logic [23:0] run_sel = 24'h0, wake_req = 24'h0, clk_en;
	logic [7:0] fast;
	logic [3:0] lvl;
	int failures = 0;
	int samples_checked = 0;
	// ****************
	// Design and partner
	// ****************
	sysctl_irq_sleep #(.FLASH_SIZE_BYTES(FLASH)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .main_osc_powerup_irq_i(osc),
		.pll_locked_irq_i(pll), .brownout_irq_i(bor), .power_mode_i(pm),
		.periph_run_sel_i(run_sel), .periph_wake_req_i(wake_req), .periph_clk_en_o(clk_en),
		.wake_o(wake), .irq_o(irq), .gpio_fast_sel_o(fast), .regulator_level_code_o(lvl));
	event_source src (.clk_i(clk_i), .fire_i(fire), .osc_o(osc), .pll_o(pll), .bor_o(bor));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Holds the request until ack is sampled, then releases for at least one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50) begin
			failures++;
			end_of_test();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask
	task automatic pulse(input logic [2:0] f);
		@(posedge clk_i);
		fire <= f;
		@(posedge clk_i);
		fire <= 3'h0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic test_reset;
		check("irq after reset", irq, 1'b0);
		check("fast port after reset", fast, 8'h00);
		check("level port after reset", lvl, REG_LEVEL_NOMINAL);
		rd_chk("enable reset", REG_IRQ_ENABLE, 32'h0);
		rd_chk("gating reset", REG_GATING_CTRL, 32'h0);
		rd_chk("fast reset", REG_GPIO_FAST_SEL, 32'h0);
		rd_chk("level reset", REG_REGULATOR_CTRL, 32'h5);
		wb(1'b1, REG_FLASH_SIZE, 32'h0000_1234);
		rd_chk("flash size", REG_FLASH_SIZE, FLASH);
		wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		rd_chk("unmapped", 8'h3C, 32'h0);
		$display("test reset done");
	endtask
	task automatic test_irq;
		for (int i = 0; i < NUM_IRQ; i++) begin
			pulse(3'h1 << i);
			rd_chk("single source", REG_IRQ_RAW, 32'h1 << i);
			wb(1'b1, REG_IRQ_CLEAR, 32'h1 << i);
		end
		pulse(3'h7);
		tick(20);
		rd_chk("raw sticky", REG_IRQ_RAW, 32'h7);
		check("irq disabled", irq, 1'b0);
		rd_chk("masked none", REG_IRQ_MASKED, 32'h0);
		wb(1'b1, REG_IRQ_ENABLE, 32'h2);
		tick(3);
		check("irq enabled", irq, 1'b1);
		rd_chk("masked pll", REG_IRQ_MASKED, 32'h2);
		wb(1'b1, REG_VIEW_CTRL, 32'h1);
		rd_chk("view masked", REG_IRQ_VIEW, 32'h2);
		wb(1'b1, REG_VIEW_CTRL, 32'h0);
		rd_chk("view raw", REG_IRQ_VIEW, 32'h7);
		// Handler clears the PLL source after reading the masked and view status
		wb(1'b1, REG_IRQ_CLEAR, 32'h2);
		rd_chk("clear one", REG_IRQ_RAW, 32'h5);
		tick(2);
		check("irq after clear", irq, 1'b0);
		rd_chk("clear reads zero", REG_IRQ_CLEAR, 32'h0);
		wb(1'b1, REG_IRQ_CLEAR, 32'h5);
		rd_chk("clear rest", REG_IRQ_RAW, 32'h0);
		$display("test irq done");
	endtask
	task automatic test_level;
		for (int c = 0; c <= 10; c++) begin
			wb(1'b1, REG_REGULATOR_CTRL, c);
			rd_chk("level readback", REG_REGULATOR_CTRL, c);
			check("level port", lvl, c[3:0]);
		end
		wb(1'b1, REG_REGULATOR_CTRL, 32'hB);
		rd_chk("level out of range", REG_REGULATOR_CTRL, 32'hA);
		wb(1'b1, REG_REGULATOR_CTRL, 32'h5);
		$display("test level done");
	endtask
	task automatic test_fast;
		// Each write requests a change to one port; port d is not selectable, so the 32'h09 write changes nothing
		wb(1'b1, REG_GPIO_FAST_SEL, 32'h01);
		tick(1);
		check("port a fast", fast, 8'h01);
		wb(1'b1, REG_GPIO_FAST_SEL, 32'h09);
		rd_chk("port d not selectable", REG_GPIO_FAST_SEL, 32'h01);
		wb(1'b1, REG_GPIO_FAST_SEL, 32'h00);
		tick(1);
		check("port a slow", fast, 8'h00);
		$display("test fast done");
	endtask
	task automatic test_gating;
		run_sel <= 24'h00FFF3;
		wb(1'b1, REG_SLEEP_SEL, 32'h0F);
		wb(1'b1, REG_DEEP_SEL, 32'hF0);
		pm <= MODE_DEEP;
		tick(3);
		check("deep ungated", clk_en, 24'h00FFF3);
		rd_chk("deep sel kept", REG_DEEP_SEL, 32'hF0);
		wb(1'b1, REG_GATING_CTRL, 32'h1);
		tick(2);
		check("deep gated", clk_en, 24'h0000F0);
		wake_req <= 24'h000010;
		tick(2);
		check("deep wake", wake, 1'b1);
		wake_req <= 24'h000001;
		tick(2);
		check("deep no wake", wake, 1'b0);
		pm <= MODE_SLEEP;
		tick(2);
		check("sleep gated", clk_en, 24'h000003);
		check("sleep wake", wake, 1'b1);
		pm <= MODE_RUN;
		tick(2);
		check("run", clk_en, 24'h00FFF3);
		check("run wake", wake, 1'b0);
		$display("test gating done");
	endtask
	// ****************
	// Verdict
	// ****************
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		test_reset();
		test_irq();
		test_level();
		test_fast();
		test_gating();
		end_of_test();
	end
endmodule
